// *** rtl/ext_branch_pkg.sv ***
// Shared constants and types for the extended greater-than / less-or-equal branch unit
package ext_branch_pkg;

    // ------------------------------------------------------------------
    // Instruction fields (bit 0 of the printed layout is word bit 31)
    // ------------------------------------------------------------------
    localparam logic [5:0] OPC_REG_FORM = 6'h27;
    localparam logic [5:0] OPC_IMM_FORM = 6'h2F;
    localparam logic [3:0] COND_GT      = 4'hC;
    localparam logic [3:0] COND_LE      = 4'hB;
    localparam int         OPC_MSB      = 31;
    localparam int         OPC_LSB      = 26;
    localparam int         SLOT_BIT     = 25;
    localparam int         COND_MSB     = 24;
    localparam int         COND_LSB     = 21;
    localparam int         WIDE_BIT     = 8;
    localparam int         IMM_MSB      = 15;

    // ------------------------------------------------------------------
    // Latencies in core cycles
    // ------------------------------------------------------------------
    typedef logic [3:0] latency_t;
    localparam latency_t LAT_NOT_TAKEN    = 4'h1;
    localparam latency_t LAT_TAKEN_SLOT   = 4'h2;
    localparam latency_t LAT_TAKEN_NOSLOT = 4'h3;
    localparam latency_t LAT_MISP_FAST    = 4'h3;
    localparam latency_t LAT_MISP_SMALL   = 4'h8;
    localparam logic [63:0] PC_STEP       = 64'h4;

    // ------------------------------------------------------------------
    // Size tuning option values and register map
    // ------------------------------------------------------------------
    localparam logic [1:0]  SIZE_OPT_FAST  = 2'h0;
    localparam logic [1:0]  SIZE_OPT_SMALL = 2'h2;
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_STAT       = 8'h04;
    localparam logic [7:0]  REG_TGT_LO     = 8'h08;
    localparam logic [7:0]  REG_TGT_HI     = 8'h0C;
    localparam logic [1:0]  CTRL_RESET     = 2'h0;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;

endpackage

// *** rtl/branch_decode_if.sv ***
// Carrier between the core of the branch unit and its condition decoder
`timescale 1ns/10ps
interface branch_decode_if;
    logic [31:0] instr;
    logic [63:0] pc;
    logic [63:0] src;
    logic [63:0] ofs;
    logic        prefix_valid;
    logic        prefix_wide;
    logic [47:0] prefix_imm;
    logic        hit;
    logic        is_imm;
    logic        slot;
    logic        wide;
    logic        taken;
    logic [63:0] target;

    modport dec (input instr, pc, src, ofs, prefix_valid, prefix_wide, prefix_imm,
                 output hit, is_imm, slot, wide, taken, target);
    modport core (output instr, pc, src, ofs, prefix_valid, prefix_wide, prefix_imm,
                  input hit, is_imm, slot, wide, taken, target);
endinterface

// *** rtl/branch_cond_decoder.sv ***
// Field decode, zero compare and target computation for one branch word
`timescale 1ns/10ps
module branch_cond_decoder (
    // Decode carrier
    branch_decode_if.dec b
);
    import ext_branch_pkg::*;

    logic [5:0]  opc;
    logic [3:0]  cond;
    logic [15:0] imm;
    logic [63:0] val;
    logic [63:0] imm_ofs;
    logic        gt;

    // Fields, width choice and signed compare against zero
    always_comb begin
        opc      = b.instr[OPC_MSB:OPC_LSB];
        cond     = b.instr[COND_MSB:COND_LSB];
        imm      = b.instr[IMM_MSB:0];
        b.is_imm = (opc == OPC_IMM_FORM);
        b.hit    = (b.is_imm || opc == OPC_REG_FORM) && (cond == COND_GT || cond == COND_LE);
        b.slot   = b.instr[SLOT_BIT];
        b.wide   = b.is_imm ? (b.prefix_valid && b.prefix_wide)
                            : b.instr[WIDE_BIT];
        val      = b.wide ? b.src : {{32{b.src[31]}}, b.src[31:0]};
        gt       = ($signed(val) > $signed(64'h0));
        b.taken  = b.hit && ((cond == COND_GT) ? gt : !gt);
    end

    // Offset: plain sign extension unless a prefix supplied upper bits
    always_comb begin
        if (!b.prefix_valid) begin
            imm_ofs = {{48{imm[15]}}, imm};
        end else if (b.prefix_wide) begin
            imm_ofs = {b.prefix_imm, imm};
        end else begin
            imm_ofs = {{32{b.prefix_imm[15]}}, b.prefix_imm[15:0], imm};
        end
        b.target = b.taken ? b.pc + (b.is_imm ? imm_ofs : b.ofs)
                           : b.pc + PC_STEP;
    end

endmodule

// *** rtl/branch_latency_timer.sv ***
// Counts the cycles a branch holds the pipeline and marks the PC update
`timescale 1ns/10ps
module branch_latency_timer (
    // Clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_b,
    // Start request
    input  wire logic                     i_start,
    input  wire ext_branch_pkg::latency_t i_latency,
    // Progress
    output logic                          o_busy,
    output logic                          o_done
);
    import ext_branch_pkg::*;

    typedef enum logic {T_IDLE, T_COUNT} timer_state_t;

    timer_state_t state;
    timer_state_t next_state;
    latency_t     remain;
    latency_t     next_remain;
    logic         next_busy;
    logic         next_done;

    // Next state: a one-cycle branch finishes at the start edge itself
    always_comb begin
        next_state  = state;
        next_remain = remain;
        next_busy   = o_busy;
        next_done   = 1'b0;
        unique case (state)
            T_IDLE: begin
                if (i_start) begin
                    if (i_latency <= LAT_NOT_TAKEN) begin
                        next_done = 1'b1;
                    end else begin
                        next_state  = T_COUNT;
                        next_remain = i_latency - LAT_NOT_TAKEN;
                        next_busy   = 1'b1;
                    end
                end
            end
            T_COUNT: begin
                next_remain = remain - LAT_NOT_TAKEN;
                if (remain == LAT_NOT_TAKEN) begin
                    next_state = T_IDLE;
                    next_busy  = 1'b0;
                    next_done  = 1'b1;
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state  <= T_IDLE;
            remain <= 4'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            state  <= next_state;
            remain <= next_remain;
            o_busy <= next_busy;
            o_done <= next_done;
        end
    end

endmodule

// *** rtl/ext_branch_gt_le_unit.sv ***
// Extended-address branch unit for greater-than and less-or-equal zero tests
//
// Functional notes
// - Greater-than taken when operand above zero
// - Less-or-equal taken when operand not above zero
// - Register form wide bit picks 64-bit compare
// - Delay variants carry the wait-slot bit
// - Taken with slot lets next instruction finish
// - Taken without slot skips next instruction
// - Immediate target is PC plus extended offset
// - Wide compare only after wide prefix
// - No prefix: sign-extend 16-bit offset
// - Prefix bits join the offset field
// - Register latency one, two or three cycles
// - Good prediction one cycle, fast mispredict three
// - Small-size mispredict costs seven to nine cycles
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module ext_branch_gt_le_unit (
    // Clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST_B,
    // Issued instruction and operands
    input  wire logic        I_INSTR_VALID,
    input  wire logic [31:0] I_INSTR,
    input  wire logic [63:0] I_PC,
    input  wire logic [63:0] I_SRC_VAL,
    input  wire logic [63:0] I_OFS_VAL,
    // Preceding prefix instruction
    input  wire logic        I_PREFIX_VALID,
    input  wire logic        I_PREFIX_WIDE,
    input  wire logic [47:0] I_PREFIX_IMM,
    // Branch prediction
    input  wire logic        I_PREDICT_VALID,
    input  wire logic        I_PREDICT_TAKEN,
    // Pipeline control
    output logic             O_BUSY,
    output logic             O_PC_WE,
    output logic [63:0]      O_NEXT_PC,
    output logic             O_TAKEN,
    output logic             O_SLOT_EXEC,
    output logic             O_FLUSH,
    // AHB-Lite slave
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic        I_HREADY,
    input  wire logic [31:0] I_HWDATA,
    output logic [31:0]      O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP
);
    import ext_branch_pkg::*;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    branch_decode_if dec ();

    assign dec.instr        = I_INSTR;
    assign dec.pc           = I_PC;
    assign dec.src          = I_SRC_VAL;
    assign dec.ofs          = I_OFS_VAL;
    assign dec.prefix_valid = I_PREFIX_VALID;
    assign dec.prefix_wide  = I_PREFIX_WIDE;
    assign dec.prefix_imm   = I_PREFIX_IMM;

    branch_cond_decoder u_dec (
        .b (dec.dec)
    );

    // ------------------------------------------------------------------
    // Issue and latency choice
    // ------------------------------------------------------------------
    logic        accept;
    logic        mispredict;
    latency_t    lat;
    logic [1:0]  size_opt;

    // New branch only while the previous one is not holding the pipe
    always_comb begin
        accept     = I_INSTR_VALID && dec.hit && !O_BUSY;
        mispredict = dec.is_imm && I_PREDICT_VALID && (I_PREDICT_TAKEN != dec.taken);
        if (dec.is_imm && I_PREDICT_VALID && !mispredict) begin
            lat = LAT_NOT_TAKEN;
        end else if (mispredict) begin
            lat = (size_opt == SIZE_OPT_SMALL) ? LAT_MISP_SMALL
                                               : LAT_MISP_FAST;
        end else if (!dec.taken) begin
            lat = LAT_NOT_TAKEN;
        end else if (dec.slot) begin
            lat = LAT_TAKEN_SLOT;
        end else begin
            lat = LAT_TAKEN_NOSLOT;
        end
    end

    // Timer owns busy and the PC write strobe
    branch_latency_timer u_timer (
        .i_clk     (I_SYS_CLK),
        .i_rst_b   (I_RST_B),
        .i_start   (accept),
        .i_latency (lat),
        .o_busy    (O_BUSY),
        .o_done    (O_PC_WE)
    );

    // ------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------
    logic [63:0] next_next_pc;
    logic        next_taken;
    logic        next_slot_exec;
    logic        next_flush;
    logic [15:0] taken_cnt;
    logic [15:0] next_taken_cnt;

    // Target is held from issue so it is stable when the strobe fires
    always_comb begin
        next_next_pc   = O_NEXT_PC;
        next_taken     = O_TAKEN;
        next_slot_exec = 1'b0;
        next_flush     = 1'b0;
        next_taken_cnt = taken_cnt;
        if (accept) begin
            next_next_pc   = dec.target;
            next_taken     = dec.taken;
            next_slot_exec = dec.taken && dec.slot;
            // A mispredicted taken branch with a slot still lets the slot finish
            next_flush     = dec.taken ? !dec.slot : mispredict;
            next_taken_cnt = taken_cnt + {15'h0, dec.taken};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_NEXT_PC   <= 64'h0;
            O_TAKEN     <= 1'b0;
            O_SLOT_EXEC <= 1'b0;
            O_FLUSH     <= 1'b0;
            taken_cnt   <= 16'h0;
        end else begin
            O_NEXT_PC   <= next_next_pc;
            O_TAKEN     <= next_taken;
            O_SLOT_EXEC <= next_slot_exec;
            O_FLUSH     <= next_flush;
            taken_cnt   <= next_taken_cnt;
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite register slave
    // ------------------------------------------------------------------
    logic        ap;
    logic        wr_pend;
    logic        next_wr_pend;
    logic [7:0]  addr_q;
    logic [7:0]  next_addr_q;
    logic [1:0]  next_size_opt;
    logic [31:0] next_rdata;
    logic [31:0] rd_mux;

    // Zero wait states: read data is prepared in the address phase,
    // forwarding a control write still in its data phase
    always_comb begin
        ap            = I_HSEL && I_HTRANS[1] && I_HREADY && (I_HSIZE == HSIZE_WORD);
        next_wr_pend  = ap && I_HWRITE;
        next_addr_q   = ap ? I_HADDR[7:0] : addr_q;
        next_size_opt = size_opt;
        if (wr_pend && addr_q == REG_CTRL) begin
            next_size_opt = I_HWDATA[1:0];
        end
        unique case (I_HADDR[7:0])
            REG_CTRL:   rd_mux = {30'h0, next_size_opt};
            REG_STAT:   rd_mux = {taken_cnt, 14'h0, O_TAKEN, O_BUSY};
            REG_TGT_LO: rd_mux = O_NEXT_PC[31:0];
            REG_TGT_HI: rd_mux = O_NEXT_PC[63:32];
            default:    rd_mux = 32'h0;
        endcase
        next_rdata = (ap && !I_HWRITE) ? rd_mux : 32'h0;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            wr_pend     <= 1'b0;
            addr_q      <= 8'h00;
            size_opt    <= CTRL_RESET;
            O_HRDATA    <= 32'h0;
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
        end else begin
            wr_pend     <= next_wr_pend;
            addr_q      <= next_addr_q;
            size_opt    <= next_size_opt;
            O_HRDATA    <= next_rdata;
            O_HREADYOUT <= 1'b1;
            O_HRESP     <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions and cover points
    // ------------------------------------------------------------------
    logic is_gt;
    logic is_reg;

    assign is_gt  = (I_INSTR[COND_MSB:COND_LSB] == COND_GT);
    assign is_reg = (I_INSTR[OPC_MSB:OPC_LSB] == OPC_REG_FORM);

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    a_gt_wide_compare: assert property (
        accept && is_gt && dec.wide |-> dec.taken == ($signed(I_SRC_VAL) > 0))
        else $error("greater-than decision wrong");

    a_le_wide_compare: assert property (
        accept && !is_gt && dec.wide |-> dec.taken == ($signed(I_SRC_VAL) <= 0))
        else $error("less-or-equal decision wrong");

    a_narrow_compare: assert property (
        accept && !dec.wide |-> dec.taken ==
            (is_gt ? ($signed(I_SRC_VAL[31:0]) > 0) : ($signed(I_SRC_VAL[31:0]) <= 0)))
        else $error("narrow compare used wrong bits");

    a_reg_wide_select: assert property (
        accept && is_reg |-> dec.wide == I_INSTR[WIDE_BIT] && dec.slot == I_INSTR[SLOT_BIT])
        else $error("register form field decode wrong");

    a_imm_wide_prefix: assert property (
        accept && dec.is_imm |-> dec.wide == (I_PREFIX_VALID && I_PREFIX_WIDE))
        else $error("immediate compare width wrong");

    a_imm_sext_target: assert property (
        accept && dec.is_imm && dec.taken && !I_PREFIX_VALID |=>
            O_NEXT_PC == $past(I_PC) + {{48{$past(I_INSTR[15])}}, $past(I_INSTR[15:0])})
        else $error("sign-extended target wrong");

    a_wide_prefix_target: assert property (
        accept && dec.is_imm && dec.taken && I_PREFIX_VALID && I_PREFIX_WIDE |=>
            O_NEXT_PC == $past(I_PC) + {$past(I_PREFIX_IMM), $past(I_INSTR[15:0])})
        else $error("prefixed target wrong");

    a_narrow_prefix_target: assert property (
        accept && dec.is_imm && dec.taken && I_PREFIX_VALID && !I_PREFIX_WIDE |=>
            O_NEXT_PC == $past(I_PC) +
                {{32{$past(I_PREFIX_IMM[15])}}, $past(I_PREFIX_IMM[15:0]), $past(I_INSTR[15:0])})
        else $error("narrow prefixed target wrong");

    a_reg_target: assert property (
        accept && is_reg && dec.taken |=> O_NEXT_PC == $past(I_PC) + $past(I_OFS_VAL))
        else $error("register target wrong");

    a_not_taken_step: assert property (
        accept && !dec.taken |=> O_NEXT_PC == $past(I_PC) + PC_STEP && !O_TAKEN)
        else $error("fall-through address wrong");

    a_not_taken_one: assert property (
        accept && !dec.taken && !I_PREDICT_VALID |=> O_PC_WE && !O_BUSY)
        else $error("not-taken latency wrong");

    a_taken_slot_two: assert property (
        accept && dec.taken && dec.slot && !I_PREDICT_VALID |=> !O_PC_WE ##1 O_PC_WE)
        else $error("taken slot latency wrong");

    a_taken_noslot_three: assert property (
        accept && dec.taken && !dec.slot && !I_PREDICT_VALID |=>
            !O_PC_WE [*2] ##1 O_PC_WE)
        else $error("taken no-slot latency wrong");

    a_slot_release: assert property (
        accept && dec.taken && dec.slot |=> O_SLOT_EXEC && !O_FLUSH)
        else $error("delay slot not released");

    a_noslot_flush: assert property (
        accept && dec.taken && !dec.slot |=> O_FLUSH && !O_SLOT_EXEC)
        else $error("sequential instruction not squashed");

    a_predict_hit: assert property (
        accept && dec.is_imm && I_PREDICT_VALID && !mispredict |=> O_PC_WE)
        else $error("predicted branch slow");

    a_misp_fast: assert property (
        accept && mispredict && size_opt != SIZE_OPT_SMALL |=> !O_PC_WE [*2] ##1 O_PC_WE)
        else $error("fast mispredict cost wrong");

    a_misp_small: assert property (
        accept && mispredict && size_opt == SIZE_OPT_SMALL |=>
            !O_PC_WE [*6] ##1 !O_PC_WE ##1 O_PC_WE)
        else $error("small mispredict cost wrong");

    c_gt_taken_slot: cover property (accept && is_gt && dec.taken && dec.slot);
    c_le_taken_noslot: cover property (accept && !is_gt && dec.taken && !dec.slot);
    c_misp_small: cover property (accept && mispredict && size_opt == SIZE_OPT_SMALL);
    c_ctrl_write: cover property (wr_pend && addr_q == REG_CTRL);
    c_misp_taken_slot: cover property (accept && mispredict && dec.taken && dec.slot);

endmodule

// *** tb/ext_branch_gt_le_unit_bench.sv ***
// Self-checking bench for the extended greater-than / less-or-equal branch unit
`timescale 1ns/10ps
module ext_branch_gt_le_unit_bench;
    import ext_branch_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic        I_SYS_CLK      = 1'b0;
    logic        I_RST_B        = 1'b0;
    logic        I_INSTR_VALID  = 1'b0;
    logic [31:0] I_INSTR        = 32'h0;
    logic [63:0] I_PC           = 64'h0000_0001_0000_1000;
    logic [63:0] I_SRC_VAL      = 64'h0;
    logic [63:0] I_OFS_VAL      = 64'hFFFF_FFFF_FFFF_FF00;
    logic        I_PREFIX_VALID = 1'b0;
    logic        I_PREFIX_WIDE  = 1'b0;
    logic [47:0] I_PREFIX_IMM   = 48'h0000_0123_4567;
    logic        I_PREDICT_VALID = 1'b0;
    logic        I_PREDICT_TAKEN = 1'b0;
    logic        I_HSEL         = 1'b0;
    logic [31:0] I_HADDR        = 32'h0;
    logic [1:0]  I_HTRANS       = 2'h0;
    logic        I_HWRITE       = 1'b0;
    logic [2:0]  I_HSIZE        = 3'h0;
    logic [31:0] I_HWDATA       = 32'h0;
    logic        O_BUSY, O_PC_WE, O_TAKEN, O_SLOT_EXEC, O_FLUSH;
    logic        O_HREADYOUT, O_HRESP;
    logic [63:0] O_NEXT_PC;
    logic [31:0] O_HRDATA;
    logic [31:0] q;
    int          fails          = 0;
    int          checked        = 0;

    always #5 I_SYS_CLK = ~I_SYS_CLK;

    ext_branch_gt_le_unit u_dut (
        .I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .I_INSTR_VALID(I_INSTR_VALID),
        .I_INSTR(I_INSTR), .I_PC(I_PC), .I_SRC_VAL(I_SRC_VAL), .I_OFS_VAL(I_OFS_VAL),
        .I_PREFIX_VALID(I_PREFIX_VALID), .I_PREFIX_WIDE(I_PREFIX_WIDE),
        .I_PREFIX_IMM(I_PREFIX_IMM), .I_PREDICT_VALID(I_PREDICT_VALID),
        .I_PREDICT_TAKEN(I_PREDICT_TAKEN), .O_BUSY(O_BUSY), .O_PC_WE(O_PC_WE),
        .O_NEXT_PC(O_NEXT_PC), .O_TAKEN(O_TAKEN), .O_SLOT_EXEC(O_SLOT_EXEC),
        .O_FLUSH(O_FLUSH), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
        .I_HWRITE(I_HWRITE), .I_HSIZE(I_HSIZE), .I_HREADY(O_HREADYOUT),
        .I_HWDATA(I_HWDATA), .O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT),
        .O_HRESP(O_HRESP)
    );

    // ----------------------------------------------------------------
    // Checking and reference model
    // ----------------------------------------------------------------
    task automatic results();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bit 64 is the direction, the rest the next PC
    function automatic logic [64:0] model(input logic [31:0] w);
        logic [63:0] v, o;
        logic        im, wd;
        im = (w[31:26] === OPC_IMM_FORM);
        wd = im ? (I_PREFIX_VALID & I_PREFIX_WIDE) : w[8];
        v  = wd ? I_SRC_VAL : {{32{I_SRC_VAL[31]}}, I_SRC_VAL[31:0]};
        if (!im) o = I_OFS_VAL;
        else if (!I_PREFIX_VALID) o = {{48{w[15]}}, w[15:0]};
        else if (I_PREFIX_WIDE) o = {I_PREFIX_IMM, w[15:0]};
        else o = {{32{I_PREFIX_IMM[15]}}, I_PREFIX_IMM[15:0], w[15:0]};
        model[64]   = (w[24:21] === 4'hC) ? ($signed(v) > 0) : ($signed(v) <= 0);
        model[63:0] = model[64] ? I_PC + o : I_PC + 64'h4;
    endfunction

    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    // Issue one branch word with its operands, then count edges to the PC write pulse;
    // lat 0 asks for the plain 1/2/3 cycle cost of the unpredicted branch
    task automatic go(input logic [31:0] w, input int lat, input logic [63:0] src,
                      input logic [1:0] pfx, input logic [1:0] prd);
        logic [64:0] e;
        logic        pr;
        int          n;
        @(posedge I_SYS_CLK);
        I_INSTR_VALID   <= 1'b1;
        I_INSTR         <= w;
        I_SRC_VAL       <= src;
        I_PREFIX_VALID  <= pfx[1];
        I_PREFIX_WIDE   <= pfx[0];
        I_PREDICT_VALID <= prd[1];
        I_PREDICT_TAKEN <= prd[0];
        @(posedge I_SYS_CLK);
        I_INSTR_VALID <= 1'b0;
        e  = model(w);
        pr = (w[31:26] === OPC_IMM_FORM) && prd[1];
        if (lat == 0) lat = e[64] ? (w[25] ? 2 : 3) : 1;
        #1;
        n = 1;
        chk(O_NEXT_PC, e[63:0]);
        chk(O_TAKEN, e[64]);
        chk(O_BUSY, lat > 1);
        chk(O_PC_WE, lat == 1);
        chk(O_SLOT_EXEC, e[64] & w[25]);
        chk(O_FLUSH, e[64] ? !w[25] : (pr && lat > 1));
        while (O_PC_WE !== 1'b1 && n < 20) begin
            @(posedge I_SYS_CLK);
            #1;
            n++;
        end
        chk(n, lat);
        if (n >= 20) results();
    endtask

    // One AHB-Lite single word transfer; read data taken at the data edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge I_SYS_CLK);
        I_HSEL   <= 1'b1;
        I_HTRANS <= 2'h2;
        I_HADDR  <= a;
        I_HWRITE <= wr;
        I_HSIZE  <= HSIZE_WORD;
        k = 0;
        do begin
            @(posedge I_SYS_CLK);
            k++;
        end while (O_HREADYOUT !== 1'b1 && k < 50);
        I_HTRANS <= 2'h0;
        I_HWDATA <= d;
        do begin
            @(posedge I_SYS_CLK);
            k++;
        end while (O_HREADYOUT !== 1'b1 && k < 100);
        q = O_HRDATA;
        chk(O_HRESP, 1'b0);
        if (k >= 100) begin
            fails++;
            results();
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        chk({O_BUSY, O_PC_WE, O_FLUSH, O_HREADYOUT}, 4'h1);
        bus(1'b0, 32'h0, 32'h0);
        chk(q, 32'h0);
    endtask

    // Both forms, both conditions, slot and wide, signed boundary operands
    task automatic t_forms();
        logic [63:0] vals[5];
        logic [3:0]  cnd;
        logic [31:0] w;
        vals = '{64'h0, 64'h1, 64'hFFFF_FFFF_FFFF_FFFF,
                 64'h0000_0001_8000_0000, 64'hFFFF_FFFF_0000_0005};
        for (int f = 0; f < 2; f++) begin
            for (int p = 0; p <= 2 * f; p++) begin
                for (int c = 0; c < 2; c++) begin
                    for (int s = 0; s < 2; s++) begin
                        for (int wd = 0; wd <= 1 - f; wd++) begin
                            for (int v = 0; v < 5; v++) begin
                                cnd            = c ? 4'hB : 4'hC;
                                w              = {f ? OPC_IMM_FORM : OPC_REG_FORM, s[0],
                                                  cnd, 5'h3, 16'h8004};
                                if (!f) w[15:0] = {5'h4, 2'h0, wd[0], 8'h0};
                                go(w, 0, vals[v], {p != 0, p == 2}, 2'b00);
                            end
                        end
                    end
                end
            end
        end
    endtask

    // Prediction hits under the fast size tuning setting, misses under both size tuning settings
    task automatic t_pred();
        logic [31:0] w;
        w = {OPC_IMM_FORM, 1'b0, 4'hC, 5'h3, 16'h0040};
        go(w, 1, 64'h1, 2'b00, 2'b11);
        go(w, 3, 64'h1, 2'b00, 2'b10);
        bus(1'b1, 32'h0, 32'h2);
        bus(1'b0, 32'h0, 32'h0);
        chk(q[1:0], 2'h2);
        go(w, 8, 64'h1, 2'b00, 2'b10);
        w[25] = 1'b1;
        go(w, 8, 64'h1, 2'b00, 2'b10);
        go(w, 8, 64'h0, 2'b00, 2'b11);
        bus(1'b0, 32'h4, 32'h0);
        chk(q[1:0], 2'h0);
        bus(1'b0, 32'h8, 32'h0);
        chk(q, 32'h0000_1004);
        bus(1'b0, 32'hC, 32'h0);
        chk(q, 32'h0000_0001);
        bus(1'b0, 32'h40, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 32'h0, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge I_SYS_CLK);
        I_RST_B <= 1'b1;
        @(posedge I_SYS_CLK);
        #1;
        t_reset();
        t_forms();
        t_pred();
        results();
    end
endmodule
